// *** inc/msrse_pkg.sv ***
package msrse_pkg;
    // -----------------------------------------------------------------
    // register indices
    // -----------------------------------------------------------------
    localparam logic [31:0] IDX_FEATURE_ENABLE = 32'hc000_0080;
    localparam logic [31:0] IDX_FAST_SYSTEM_CALL_TARGET = 32'hc000_0081;
    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int FCE_BIT = 0;
    localparam int RET_SEL_LSB = 48;
    localparam int CALL_SEL_LSB = 32;
    localparam int TARGET_IP_LSB = 0;
    localparam int HI_HALF_LSB = 32;
    // -----------------------------------------------------------------
    // reset values, write mask and select encoding
    // -----------------------------------------------------------------
    localparam logic [63:0] FEATURE_ENABLE_RST = 64'h0000_0000_0000_0000;
    localparam logic [63:0] FAST_SYSTEM_CALL_TARGET_RST = 64'h0000_0000_0000_0000;
    localparam logic [63:0] FEATURE_ENABLE_WMASK = 64'h0000_0000_0000_0001;
    typedef enum logic [1:0] {MSRSE_SEL_NONE, MSRSE_SEL_FEAT, MSRSE_SEL_TGT} msrse_sel_t;
endpackage : msrse_pkg

// *** core/msrse_decode.sv ***
`timescale 1ns/1ps
module msrse_decode (
    // index in
    input wire logic [31:0] count_general_register,
    // decoded select
    output msrse_pkg::msrse_sel_t sel
);
    always_comb
    begin
        sel = msrse_pkg::MSRSE_SEL_NONE;
        if (count_general_register == msrse_pkg::IDX_FEATURE_ENABLE)
        begin
            sel = msrse_pkg::MSRSE_SEL_FEAT; // [R4]
        end
        else if (count_general_register == msrse_pkg::IDX_FAST_SYSTEM_CALL_TARGET)
        begin
            sel = msrse_pkg::MSRSE_SEL_TGT; // [R5]
        end
    end
endmodule : msrse_decode

// *** core/msrse_regs.sv ***
`timescale 1ns/1ps
// Contract
// R1 - the index in the count general register picks the register accessed.
// R2 - reads return into accumulator and data registers; writes take from them.
// R3 - data register carries bits 63..32, accumulator carries bits 31..0.
// R4 - index c000_0080 selects the extended feature enable register.
// R5 - index c000_0081 selects the fast_system_call target selectors register.
// R6 - feature enable bit 0 is the read/write fast call extension enable.
// R7 - feature enable bits 63..1 are reserved, read-only, reading zero.
// R8 - target bits 63..48 hold the return selector base, read/write.
// R9 - target bits 47..32 hold the call selector base, read/write.
// R10 - target bits 31..0 hold the call instruction pointer, read/write.
// R11 - reset clears both registers to zero.
// R12 - soft init leaves both registers unchanged.
module msrse_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // soft initialisation, same clock domain
    input wire logic soft_init,
    // model register access
    input wire logic model_register_read_instr,
    input wire logic model_register_write_instr,
    input wire logic [31:0] count_general_register,
    input wire logic [31:0] accumulator_register,
    input wire logic [31:0] data_general_register,
    // read result
    output logic [31:0] rd_accumulator_q,
    output logic [31:0] rd_data_q,
    output logic rd_valid_q,
    output logic rd_unmapped_q,
    // fields to the call/return logic
    output logic fast_call_extension_enable_q,
    output logic [15:0] ret_selector_base_q,
    output logic [15:0] call_selector_base_q,
    output logic [31:0] call_instruction_pointer_q
);
    msrse_pkg::msrse_sel_t sel;
    logic [63:0] feat_q;
    logic [63:0] feat_d;
    logic [63:0] tgt_q;
    logic [63:0] tgt_d;
    logic [63:0] wval;
    logic [63:0] rval;
    logic [31:0] rd_acc_d;
    logic [31:0] rd_data_d;
    logic rd_valid_d;
    logic rd_unm_d;
    logic wr_feat_hit;
    logic wr_tgt_hit;

    // -----------------------------------------------------------------
    // index decode
    // -----------------------------------------------------------------
    msrse_decode u_dec (
        .count_general_register(count_general_register), // [R1]
        .sel(sel)
    );

    // -----------------------------------------------------------------
    // register contents
    // -----------------------------------------------------------------
    always_comb
    begin
        wval = {data_general_register, accumulator_register}; // [R2] [R3]
        feat_d = feat_q;
        tgt_d = tgt_q;
        // soft_init deliberately has no term here: contents survive it [R12]
        if (model_register_write_instr && sel == msrse_pkg::MSRSE_SEL_FEAT)
        begin
            // reserved bits dropped on entry, so no read can ever see them
            feat_d = wval & msrse_pkg::FEATURE_ENABLE_WMASK; // [R6] [R7]
        end
        if (model_register_write_instr && sel == msrse_pkg::MSRSE_SEL_TGT)
        begin
            tgt_d = wval; // [R8] [R9] [R10]
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            feat_q <= msrse_pkg::FEATURE_ENABLE_RST; // [R11]
            tgt_q <= msrse_pkg::FAST_SYSTEM_CALL_TARGET_RST; // [R11]
            fast_call_extension_enable_q <= 1'b0;
            ret_selector_base_q <= 16'h0;
            call_selector_base_q <= 16'h0;
            call_instruction_pointer_q <= 32'h0;
        end
        else
        begin
            feat_q <= feat_d;
            tgt_q <= tgt_d;
            // fields follow the next value so they agree with the store
            fast_call_extension_enable_q <= feat_d[msrse_pkg::FCE_BIT]; // [R6]
            ret_selector_base_q <= tgt_d[msrse_pkg::RET_SEL_LSB +: 16]; // [R8]
            call_selector_base_q <= tgt_d[msrse_pkg::CALL_SEL_LSB +: 16]; // [R9]
            call_instruction_pointer_q <= tgt_d[msrse_pkg::TARGET_IP_LSB +: 32]; // [R10]
        end
    end

    // -----------------------------------------------------------------
    // read return
    // -----------------------------------------------------------------
    always_comb
    begin
        // reads the stored value, so a write in the same cycle is not seen
        rval = 64'h0;
        case (sel)
            msrse_pkg::MSRSE_SEL_FEAT: rval = feat_q;
            msrse_pkg::MSRSE_SEL_TGT: rval = tgt_q;
            default: rval = 64'h0;
        endcase
        // unmapped index reads zero and is flagged; no fault is raised here
        rd_valid_d = model_register_read_instr;
        rd_unm_d = model_register_read_instr && sel == msrse_pkg::MSRSE_SEL_NONE;
        rd_acc_d = rd_accumulator_q;
        rd_data_d = rd_data_q;
        if (model_register_read_instr)
        begin
            rd_acc_d = rval[31:0]; // [R2] [R3]
            rd_data_d = rval[63:msrse_pkg::HI_HALF_LSB];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            rd_accumulator_q <= 32'h0;
            rd_data_q <= 32'h0;
            rd_valid_q <= 1'b0;
            rd_unmapped_q <= 1'b0;
        end
        else
        begin
            rd_accumulator_q <= rd_acc_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            rd_unmapped_q <= rd_unm_d;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // decoded apart from the design's own select, so a decode slip shows
    assign wr_feat_hit = model_register_write_instr
        && count_general_register == msrse_pkg::IDX_FEATURE_ENABLE;
    assign wr_tgt_hit = model_register_write_instr
        && count_general_register == msrse_pkg::IDX_FAST_SYSTEM_CALL_TARGET;

    sequence wr_feat_s;
        wr_feat_hit;
    endsequence

    sequence wr_tgt_s;
        wr_tgt_hit;
    endsequence

    sequence wr_tgt_then_idle_s;
        wr_tgt_hit ##1 !wr_tgt_hit;
    endsequence

    index_select_a: assert property ( // [R1]
        wr_feat_s |=> fast_call_extension_enable_q == $past(accumulator_register[0]))
    else
        $error("feature write not applied");

    read_pair_a: assert property ( // [R2] [R5]
        model_register_read_instr && !model_register_write_instr
            && count_general_register == msrse_pkg::IDX_FAST_SYSTEM_CALL_TARGET
        |=> rd_valid_q && rd_accumulator_q == call_instruction_pointer_q
            && rd_data_q == {ret_selector_base_q, call_selector_base_q})
    else
        $error("target read mismatch");

    half_order_a: assert property ( // [R3]
        wr_tgt_s |=> call_instruction_pointer_q == $past(accumulator_register)
            && ret_selector_base_q == $past(data_general_register[31:16]))
    else
        $error("half order wrong");

    feat_read_a: assert property ( // [R4]
        model_register_read_instr
            && count_general_register == msrse_pkg::IDX_FEATURE_ENABLE
        |=> rd_valid_q && !rd_unmapped_q
            && rd_accumulator_q == {31'h0, $past(fast_call_extension_enable_q)})
    else
        $error("feature read wrong");

    call_base_a: assert property ( // [R9]
        wr_tgt_s |=> call_selector_base_q == $past(data_general_register[15:0]))
    else
        $error("call base not written");

    enable_hold_a: assert property ( // [R6]
        !wr_feat_hit |=> $stable(fast_call_extension_enable_q))
    else
        $error("enable changed");

    reserved_zero_a: assert property ( // [R7]
        rd_valid_q && !rd_unmapped_q
            && $past(count_general_register) == msrse_pkg::IDX_FEATURE_ENABLE
        |-> rd_data_q == 32'h0 && rd_accumulator_q[31:1] == 31'h0)
    else
        $error("reserved nonzero");

    target_hold_a: assert property ( // [R8]
        !wr_tgt_hit [*2] |=> $stable(ret_selector_base_q)
            && $stable(call_selector_base_q) && $stable(call_instruction_pointer_q))
    else
        $error("target changed");

    init_keep_a: assert property ( // [R12]
        soft_init && !model_register_write_instr
        |=> $stable(call_selector_base_q) && $stable(fast_call_extension_enable_q))
    else
        $error("soft init altered");

    unmapped_zero_a: assert property ( // [R1]
        rd_unmapped_q |-> rd_valid_q && rd_accumulator_q == 32'h0 && rd_data_q == 32'h0)
    else
        $error("unmapped read nonzero");

    reset_clear_a: assert property ( // [R11]
        @(posedge core_clk) $rose(rst_b)
        |-> call_instruction_pointer_q == 32'h0 && !fast_call_extension_enable_q)
    else
        $error("reset not cleared");

    ip_write_a: assert property ( // [R10]
        wr_tgt_then_idle_s |=> call_instruction_pointer_q == $past(accumulator_register, 2))
    else
        $error("ip lost");
endmodule : msrse_regs

// *** bench/tb_msr_fast_system_call_extension_regs.sv ***
`timescale 1ns/1ps
module tb_msr_fast_system_call_extension_regs;
    // ---------------------------------------------
    // stimulus and model state
    // ---------------------------------------------
    logic core_clk = 1'b0, rst_b = 1'b0, soft_init = 1'b0, rd_req = 1'b0, wr_req = 1'b0;
    logic [31:0] idx = 32'h0, acc = 32'h0, dat = 32'h0, rd_lo, rd_hi, call_ip;
    logic rd_vld, rd_unm, fce;
    logic [15:0] ret_sel, call_sel;
    logic [63:0] feat_m = 64'h0, tgt_m = 64'h0;
    int bad_count = 0, total_checks = 0;
    logic [31:0] idx_tab [4] = '{msrse_pkg::IDX_FEATURE_ENABLE, msrse_pkg::IDX_FAST_SYSTEM_CALL_TARGET,
                                 32'hc000_0082, 32'h0000_0080};
    always #5 core_clk = ~core_clk;
    msrse_regs dut_u (.core_clk(core_clk), .rst_b(rst_b), .soft_init(soft_init),
        .model_register_read_instr(rd_req), .model_register_write_instr(wr_req),
        .count_general_register(idx), .accumulator_register(acc), .data_general_register(dat),
        .rd_accumulator_q(rd_lo), .rd_data_q(rd_hi), .rd_valid_q(rd_vld),
        .rd_unmapped_q(rd_unm), .fast_call_extension_enable_q(fce),
        .ret_selector_base_q(ret_sel), .call_selector_base_q(call_sel),
        .call_instruction_pointer_q(call_ip));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task print_verdict;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // one access, launched just after a falling edge; read sees the old value
    // strobes stay as set: the next call or the caller lowers them
    task op(input logic r, input logic w, input logic [31:0] ix, input logic [63:0] v);
        logic [63:0] rexp;
        logic unm;
        rexp = (ix == idx_tab[0]) ? feat_m : (ix == idx_tab[1]) ? tgt_m : 64'h0;
        unm = (ix != idx_tab[0]) && (ix != idx_tab[1]);
        rd_req = r;
        wr_req = w;
        idx = ix;
        dat = v[63:32];
        acc = v[31:0];
        @(negedge core_clk);
        if (w && ix == idx_tab[0]) feat_m = v & msrse_pkg::FEATURE_ENABLE_WMASK;
        if (w && ix == idx_tab[1]) tgt_m = v;
        if (r) chk({rd_hi, rd_lo}, rexp);
        chk({62'h0, rd_vld, rd_unm}, {62'h0, r, r & unm});
        chk({ret_sel, call_sel, call_ip}, tgt_m);
        chk({63'h0, fce}, feat_m);
    endtask : op
    // ---------------------------------------------
    // sequence
    // ---------------------------------------------
    initial
    begin
        #100000;
        bad_count++;
        print_verdict();
    end
    initial
    begin
        void'($urandom(32'h1634ea2c));
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        chk({ret_sel, call_sel, call_ip, rd_hi}, 64'h0);
        op(1'b1, 1'b1, idx_tab[0], 64'hffff_ffff_ffff_ffff);
        op(1'b1, 1'b0, idx_tab[0], 64'h0);
        op(1'b0, 1'b1, idx_tab[1], 64'h1234_5678_9abc_def0);
        op(1'b1, 1'b1, idx_tab[1], 64'h0fed_cba9_8765_4321);
        repeat (300)
        begin
            soft_init = ($urandom % 8) == 0;
            op($urandom % 2, $urandom % 2, idx_tab[$urandom % 4], {$urandom, $urandom});
        end
        soft_init = 1'b0;
        rd_req = 1'b0;
        wr_req = 1'b0;
        // second reset in mid-run, contents must clear
        rst_b = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        feat_m = 64'h0;
        tgt_m = 64'h0;
        chk({ret_sel, call_sel, call_ip, rd_hi}, 64'h0);
        op(1'b1, 1'b0, idx_tab[1], 64'h0);
        op(1'b1, 1'b0, idx_tab[0], 64'h0);
        print_verdict();
    end
endmodule : tb_msr_fast_system_call_extension_regs
